// >>> rtl/ssf_pkg.sv
package ssf_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OWN = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_ISTAT = 8'h0c;
  localparam logic [7:0] OFS_IMASK = 8'h10;

  // Control and status field positions.
  localparam int BIT_DONE = 7;
  localparam int BIT_MATCH = 6;
  localparam int BIT_BUSY = 5;
  localparam int BIT_TXSEL = 4;
  localparam int BIT_ACKOUT = 3;
  localparam int BIT_DIR = 2;
  localparam int BIT_RXACK = 0;

  // Reset values.
  localparam logic RST_DONE = 1'b1;
  localparam logic RST_RXACK = 1'b1;
  localparam logic [6:0] RST_OWN = 7'h00;

  // Interrupt status and mask layout.
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_MATCH = 1;
  localparam int IRQ_START = 2;
  localparam int IRQ_STOP = 3;

  // Last bit index of a byte.
  localparam logic [2:0] BYTE_LAST = 3'h7;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_RX = 3'b011,
    ST_RACK = 3'b100,
    ST_TX = 3'b101,
    ST_TACK = 3'b110
  } ssf_state_t;

endpackage

// >>> rtl/ssf_axil_slave.sv
`timescale 1ns/100ps
module ssf_axil_slave #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // AXI4-Lite write channels.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side.
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic rd_en,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);

  logic aw_full_ff;
  logic w_full_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  wire aw_take = s_axi_awvalid & ~aw_full_ff;
  wire w_take = s_axi_wvalid & ~w_full_ff;

  assign s_axi_awready = ~aw_full_ff;
  assign s_axi_wready = ~w_full_ff;
  assign wr_en = aw_full_ff & w_full_ff & ~bvalid_ff;
  assign wr_addr = awaddr_ff;
  assign wr_data = wdata_ff;
  assign wr_strb = wstrb_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign rd_en = s_axi_arvalid & ~rvalid_ff;
  assign rd_addr = s_axi_araddr;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Address and data are held until both are present.
  always_ff @(posedge mclk) begin
    if (srst) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
    end else begin
      aw_full_ff <= (aw_full_ff & ~wr_en) | aw_take;
      w_full_ff <= (w_full_ff & ~wr_en) | w_take;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= ssf_pkg::RESP_OKAY;
    end else if (wr_en) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_err ? ssf_pkg::RESP_SLVERR : ssf_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= ssf_pkg::RESP_OKAY;
    end else if (rd_en) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_err ? 32'h0000_0000 : rd_data;
      rresp_ff <= rd_err ? ssf_pkg::RESP_SLVERR : ssf_pkg::RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule // ssf_axil_slave

// >>> rtl/ssf_bus_mon.sv
`timescale 1ns/100ps
module ssf_bus_mon (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // Bus levels.
  input wire logic scl_i,
  input wire logic sda_i,
  // Detected events.
  output logic scl_rise,
  output logic scl_fall,
  output logic start_det,
  output logic stop_det,
  output logic busy_flag
);

  logic scl_ff;
  logic sda_ff;
  logic busy_ff;

  assign scl_rise = scl_i & ~scl_ff;
  assign scl_fall = ~scl_i & scl_ff;
  assign start_det = scl_i & scl_ff & sda_ff & ~sda_i;
  assign stop_det = scl_i & scl_ff & ~sda_ff & sda_i;
  assign busy_flag = busy_ff;

  always_ff @(posedge mclk) begin
    if (srst) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else begin
      scl_ff <= scl_i;
      sda_ff <= sda_i;
    end
  end

  // Busy follows START and STOP on the bus.
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_ff <= 1'b0;
    end else if (start_det) begin
      busy_ff <= 1'b1; // [RULE4]
    end else if (stop_det) begin
      busy_ff <= 1'b0; // [RULE5]
    end
  end

endmodule // ssf_bus_mon

// >>> rtl/ssf_top.sv
// Functional notes
// (RULE1) Completion flag low while a byte shifts, high after eight bits; the code leaves it low after a non-matching address byte.
// (RULE2) An interrupt is raised when the completion flag goes high.
// (RULE3) Address match flag is 1 on own-address equality, otherwise 0.
// (RULE4) A START condition sets the bus busy flag.
// (RULE5) A STOP condition clears the bus busy flag.
// (RULE6) Transmit select 0 makes the slave receive, 1 makes it transmit.
// (RULE7) After eight received bits the acknowledge bit drives the ninth clock.
// (RULE8) On match the direction flag holds the master's read/write bit.
// (RULE9) Completion flag returns to 0 when the next byte begins.
`timescale 1ns/100ps
module ssf_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // AXI4-Lite write channels.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // I2C pins, open drain.
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Status towards neighbouring logic.
  output logic byte_done_flag,
  output logic addr_match_flag,
  output logic bus_busy_flag,
  output logic master_dir_flag,
  output logic slave_tx_select,
  // Interrupt.
  output logic irq
);

  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic busy;

  ssf_pkg::ssf_state_t state_ff, nxt_state;
  logic ph_ff, nxt_ph;
  logic [2:0] cnt_ff, nxt_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] rxbuf_ff, nxt_rxbuf;
  logic done_ff, nxt_done;
  logic match_ff, nxt_match;
  logic dir_ff, nxt_dir;
  logic rxack_ff, nxt_rxack;
  logic oe_ff, nxt_oe;
  logic txsel_ff;
  logic ackout_ff;
  logic [6:0] own_ff;
  logic [7:0] txdata_ff;
  logic [ssf_pkg::IRQ_W-1:0] istat_ff;
  logic [ssf_pkg::IRQ_W-1:0] imask_ff;

  ssf_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_axil (
    .mclk(mclk), .srst(srst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_strb(wr_strb), .wr_err(wr_err),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_err(rd_err)
  );

  ssf_bus_mon u_mon (
    .mclk(mclk), .srst(srst), .scl_i(scl_i), .sda_i(sda_i),
    .scl_rise(scl_rise), .scl_fall(scl_fall),
    .start_det(start_det), .stop_det(stop_det), .busy_flag(busy)
  );

  // Register decode.
  wire wsel_ctrl = wr_addr == ssf_pkg::OFS_CTRL;
  wire wsel_own = wr_addr == ssf_pkg::OFS_OWN;
  wire wsel_data = wr_addr == ssf_pkg::OFS_DATA;
  wire wsel_istat = wr_addr == ssf_pkg::OFS_ISTAT;
  wire wsel_imask = wr_addr == ssf_pkg::OFS_IMASK;
  assign wr_err = ~(wsel_ctrl | wsel_own | wsel_data | wsel_istat |
                    wsel_imask);
  wire wr_lo = wr_en & wr_strb[0];
  wire rsel_ctrl = rd_addr == ssf_pkg::OFS_CTRL;
  wire rsel_own = rd_addr == ssf_pkg::OFS_OWN;
  wire rsel_data = rd_addr == ssf_pkg::OFS_DATA;
  wire rsel_istat = rd_addr == ssf_pkg::OFS_ISTAT;
  wire rsel_imask = rd_addr == ssf_pkg::OFS_IMASK;
  assign rd_err = ~(rsel_ctrl | rsel_own | rsel_data | rsel_istat |
                    rsel_imask);

  wire [7:0] ctrl_rd = {done_ff, match_ff, busy, txsel_ff,
                        ackout_ff, dir_ff, 1'b0, rxack_ff};
  assign rd_data = rsel_ctrl ? {24'h000000, ctrl_rd} :
                   rsel_own ? {25'h0000000, own_ff} :
                   rsel_data ? {24'h000000, rxbuf_ff} :
                   rsel_istat ? {28'h0000000, istat_ff} :
                   rsel_imask ? {28'h0000000, imask_ff} :
                   32'h0000_0000;

  // Byte engine next state.
  wire addr_hit = shift_ff[6:0] == own_ff;
  wire last_bit = cnt_ff == ssf_pkg::BYTE_LAST;
  wire [7:0] shift_in = {shift_ff[6:0], sda_i};

  always_comb begin
    nxt_state = state_ff;
    nxt_ph = ph_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_rxbuf = rxbuf_ff;
    nxt_done = done_ff;
    nxt_match = match_ff;
    nxt_dir = dir_ff;
    nxt_rxack = rxack_ff;
    nxt_oe = oe_ff;
    if (stop_det) begin
      nxt_state = ssf_pkg::ST_IDLE;
      nxt_ph = 1'b0;
      nxt_oe = 1'b0;
    end else if (start_det) begin
      nxt_state = ssf_pkg::ST_ADDR;
      nxt_ph = 1'b0;
      nxt_cnt = 3'h0;
      nxt_oe = 1'b0;
      nxt_match = 1'b0;
      nxt_done = 1'b0; // [RULE1] [RULE9]
    end else begin
      unique case (state_ff)
        ssf_pkg::ST_IDLE: begin
          nxt_oe = 1'b0;
        end
        ssf_pkg::ST_ADDR: begin
          if (scl_rise) begin
            nxt_shift = shift_in;
            nxt_cnt = cnt_ff + 3'h1;
            if (last_bit) begin
              nxt_match = addr_hit; // [RULE3]
              if (addr_hit) begin
                nxt_dir = sda_i; // [RULE8]
                nxt_done = 1'b1; // [RULE1]
                nxt_state = ssf_pkg::ST_AACK;
                nxt_ph = 1'b0;
              end else begin
                nxt_state = ssf_pkg::ST_IDLE;
              end
            end
          end
        end
        ssf_pkg::ST_AACK, ssf_pkg::ST_RACK: begin
          if (scl_fall && !ph_ff) begin
            nxt_ph = 1'b1;
            if (state_ff == ssf_pkg::ST_AACK) begin
              nxt_oe = 1'b1;
            end else begin
              nxt_oe = ~ackout_ff; // [RULE7]
            end
          end else if (scl_fall) begin
            nxt_ph = 1'b0;
            nxt_cnt = 3'h0;
            nxt_done = 1'b0; // [RULE9]
            if (txsel_ff) begin
              nxt_state = ssf_pkg::ST_TX; // [RULE6]
              nxt_shift = txdata_ff;
              nxt_oe = ~txdata_ff[7];
            end else begin
              nxt_state = ssf_pkg::ST_RX; // [RULE6]
              nxt_oe = 1'b0;
            end
          end
        end
        ssf_pkg::ST_RX: begin
          if (scl_rise) begin
            nxt_shift = shift_in;
            nxt_cnt = cnt_ff + 3'h1;
            if (last_bit) begin
              nxt_rxbuf = shift_in;
              nxt_done = 1'b1; // [RULE1]
              nxt_state = ssf_pkg::ST_RACK;
              nxt_ph = 1'b0;
            end
          end
        end
        ssf_pkg::ST_TX: begin
          if (scl_rise) begin
            nxt_cnt = cnt_ff + 3'h1;
            if (last_bit) begin
              nxt_done = 1'b1; // [RULE1]
              nxt_state = ssf_pkg::ST_TACK;
              nxt_ph = 1'b0;
            end
          end else if (scl_fall) begin
            nxt_shift = {shift_ff[6:0], 1'b0};
            nxt_oe = ~shift_ff[6];
          end
        end
        ssf_pkg::ST_TACK: begin
          if (scl_fall && !ph_ff) begin
            nxt_ph = 1'b1;
            nxt_oe = 1'b0;
          end else if (scl_rise && ph_ff) begin
            nxt_rxack = sda_i;
          end else if (scl_fall) begin
            nxt_ph = 1'b0;
            nxt_cnt = 3'h0;
            if (rxack_ff) begin
              nxt_state = ssf_pkg::ST_IDLE;
            end else begin
              nxt_done = 1'b0; // [RULE9]
              nxt_state = ssf_pkg::ST_TX;
              nxt_shift = txdata_ff;
              nxt_oe = ~txdata_ff[7];
            end
          end
        end
        default: begin
          nxt_state = ssf_pkg::ST_IDLE;
          nxt_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_ff <= ssf_pkg::ST_IDLE;
      ph_ff <= 1'b0;
      cnt_ff <= 3'h0;
      shift_ff <= 8'h00;
      rxbuf_ff <= 8'h00;
      oe_ff <= 1'b0;
      done_ff <= ssf_pkg::RST_DONE;
      match_ff <= 1'b0;
      dir_ff <= 1'b0;
      rxack_ff <= ssf_pkg::RST_RXACK;
    end else begin
      state_ff <= nxt_state;
      ph_ff <= nxt_ph;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      rxbuf_ff <= nxt_rxbuf;
      oe_ff <= nxt_oe;
      done_ff <= nxt_done;
      match_ff <= nxt_match;
      dir_ff <= nxt_dir;
      rxack_ff <= nxt_rxack;
    end
  end

  // Software-written settings.
  always_ff @(posedge mclk) begin
    if (srst) begin
      txsel_ff <= 1'b0;
      ackout_ff <= 1'b0;
      own_ff <= ssf_pkg::RST_OWN;
      txdata_ff <= 8'h00;
      imask_ff <= '0;
    end else if (wr_lo) begin
      if (wsel_ctrl) begin
        txsel_ff <= wr_data[ssf_pkg::BIT_TXSEL];
        ackout_ff <= wr_data[ssf_pkg::BIT_ACKOUT];
      end
      if (wsel_own) begin
        own_ff <= wr_data[6:0];
      end
      if (wsel_data) begin
        txdata_ff <= wr_data[7:0];
      end
      if (wsel_imask) begin
        imask_ff <= wr_data[ssf_pkg::IRQ_W-1:0];
      end
    end
  end

  // Sticky events; a new event wins over a same-cycle clear.
  wire [ssf_pkg::IRQ_W-1:0] ev;
  assign ev[ssf_pkg::IRQ_DONE] = nxt_done & ~done_ff; // [RULE2]
  assign ev[ssf_pkg::IRQ_MATCH] = nxt_match & ~match_ff;
  assign ev[ssf_pkg::IRQ_START] = start_det;
  assign ev[ssf_pkg::IRQ_STOP] = stop_det;
  wire [ssf_pkg::IRQ_W-1:0] clr = (wr_lo & wsel_istat) ?
                                  wr_data[ssf_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge mclk) begin
    if (srst) begin
      istat_ff <= '0;
    end else begin
      istat_ff <= (istat_ff & ~clr) | ev;
    end
  end

  assign irq = |(istat_ff & imask_ff); // [RULE2]
  assign sda_o = 1'b0;
  assign sda_oe = oe_ff;
  assign byte_done_flag = done_ff;
  assign addr_match_flag = match_ff;
  assign bus_busy_flag = busy;
  assign master_dir_flag = dir_ff;
  assign slave_tx_select = txsel_ff;

endmodule // ssf_top

// >>> testbench/ssf_properties.sv
`timescale 1ns/100ps
module ssf_chk #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // Write channels.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Bus and status.
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_oe,
  input wire logic byte_done_flag,
  input wire logic addr_match_flag,
  input wire logic bus_busy_flag,
  input wire logic master_dir_flag,
  input wire logic slave_tx_select,
  input wire logic irq
);
  logic msk_ff;
  logic nxt_msk;
  logic mask_wr;
  // Tracks the completion bit of the interrupt mask.
  assign mask_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && s_axi_awaddr == ssf_pkg::OFS_IMASK;
  assign nxt_msk = mask_wr ? s_axi_wdata[ssf_pkg::IRQ_DONE] : msk_ff;
  always_ff @(posedge mclk) begin
    msk_ff <= srst ? 1'b0 : nxt_msk;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_start;
    scl_i && $past(scl_i) && $fell(sda_i);
  endsequence
  sequence s_stop;
    scl_i && $past(scl_i) && $rose(sda_i);
  endsequence
  AST_START_BUSY: assert property (
    s_start |-> ##[1:6] bus_busy_flag && !byte_done_flag)
    else $error("busy or done wrong after start");
  AST_START_MATCH: assert property (
    s_start |-> ##[1:6] !addr_match_flag)
    else $error("match flag not cleared by start");
  AST_STOP_FREE: assert property (
    s_stop |-> ##[1:6] !bus_busy_flag)
    else $error("busy flag not cleared by stop");
  AST_DONE_SCL: assert property (
    $rose(byte_done_flag) |-> scl_i && bus_busy_flag)
    else $error("done flag rose outside a byte clock");
  AST_DONE_IRQ: assert property (
    $rose(byte_done_flag) && msk_ff |-> ##[0:2] irq)
    else $error("no interrupt on completion");
  AST_DIR_MATCH: assert property (
    $rose(master_dir_flag) |-> addr_match_flag)
    else $error("direction flag set without match");
  AST_TXSEL_WR: assert property (
    $changed(slave_tx_select) |-> s_axi_bvalid)
    else $error("transmit select changed without a write");
  AST_OE_SCL_LOW: assert property (
    $rose(sda_oe) |-> !scl_i)
    else $error("data driven while clock high");
endmodule // ssf_chk

// >>> testbench/ssf_i2c_master.sv
`timescale 1ns/100ps
module ssf_i2c_master #(
  parameter int HALF = 8
) (
  // Clock.
  input wire logic mclk,
  // Resolved data line.
  input wire logic sda_i,
  // Open-drain drives, high pulls the line low.
  output logic scl_oe,
  output logic sda_oe
);
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Opens a frame and leaves the clock low.
  task automatic start();
    sda_oe <= 1'b0;
    hold(HALF);
    scl_oe <= 1'b0;
    hold(HALF);
    sda_oe <= 1'b1;
    hold(HALF);
    scl_oe <= 1'b1;
    hold(HALF);
  endtask
  // Closes a frame; both lines stay released afterwards.
  task automatic stop();
    sda_oe <= 1'b1;
    hold(HALF);
    scl_oe <= 1'b0;
    hold(HALF);
    sda_oe <= 1'b0;
    hold(HALF);
  endtask
  // One clock pulse; data moves only while the clock is low.
  task automatic bit_clk(input logic pull, output logic smp);
    sda_oe <= pull;
    hold(HALF);
    scl_oe <= 1'b0;
    hold(HALF / 2);
    smp = sda_i;
    hold(HALF / 2);
    scl_oe <= 1'b1;
    hold(HALF);
  endtask
  // Sends a byte MSB first; all ones leaves the line to the slave.
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      bit_clk(!d[i], q[i]);
    end
  endtask
endmodule // ssf_i2c_master

// >>> testbench/ssf_tb.sv
`timescale 1ns/100ps
module testbench;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sda_oe, irq, m_scl_oe, m_sda_oe, a;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rv;
  logic [7:0] b;
  logic byte_done_flag, addr_match_flag, bus_busy_flag;
  logic master_dir_flag, slave_tx_select;
  wire logic scl_i = !m_scl_oe;
  wire logic sda_i = !(m_sda_oe || sda_oe);
  int n_mismatch = 0, n_checks = 0;
  always #5 mclk = !mclk;
  ssf_top #(.ADDR_W(8)) i_dut (.mclk, .srst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_i,
    .sda_i, .sda_o(), .sda_oe, .byte_done_flag, .addr_match_flag,
    .bus_busy_flag, .master_dir_flag, .slave_tx_select, .irq);
  ssf_i2c_master #(.HALF(8)) i_mst (.mclk, .sda_i, .scl_oe(m_scl_oe),
    .sda_oe(m_sda_oe));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Flag order: done, match, busy, direction, transmit select, irq.
  task automatic chk_flags(input logic [5:0] m, input logic [5:0] e);
    @(negedge mclk);
    chk({26'h0, m & {byte_done_flag, addr_match_flag, bus_busy_flag,
      master_dir_flag, slave_tx_select, irq}}, {26'h0, e});
    @(posedge mclk);
  endtask
  task automatic ack(input logic e);
    i_mst.bit_clk(1'b0, a);
    chk({31'h0, a}, {31'h0, e});
  endtask
  // One register access; read data lands in rv.
  task automatic axi(input logic w, input logic [7:0] ad,
    input logic [31:0] d, input logic [1:0] er);
    logic ak, wk, rk;
    int t;
    t = 0;
    rk = 1'b0;
    rr = 'x;
    s_axi_awaddr <= ad;
    s_axi_araddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    while (!rk && t < 100) begin
      @(negedge mclk);
      ak = w ? s_axi_awready : s_axi_arready;
      wk = s_axi_wready;
      rk = w ? s_axi_bvalid : s_axi_rvalid;
      rr = w ? s_axi_bresp : s_axi_rresp;
      rv = s_axi_rdata;
      @(posedge mclk);
      if (ak && w) s_axi_awvalid <= 1'b0;
      if (ak && !w) s_axi_arvalid <= 1'b0;
      if (wk && w) s_axi_wvalid <= 1'b0;
      t++;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (!rk) begin
      n_mismatch++;
      $display("Error at %0t: register access timed out", $time);
    end
    chk({30'h0, rr}, {30'h0, er});
    @(posedge mclk);
  endtask
  task automatic t_reset();
    axi(1'b0, ssf_pkg::OFS_CTRL, 32'h0, 2'h0);
    chk(rv, 32'h81);
    axi(1'b0, 8'h14, 32'h0, 2'h2);
    axi(1'b1, 8'h14, 32'h0, 2'h2);
    chk_flags(6'h3f, 6'h20);
  endtask
  task automatic t_write();
    axi(1'b1, ssf_pkg::OFS_OWN, 32'h2a, 2'h0);
    axi(1'b1, ssf_pkg::OFS_IMASK, 32'hf, 2'h0);
    i_mst.start();
    axi(1'b1, ssf_pkg::OFS_ISTAT, 32'hf, 2'h0);
    chk_flags(6'h3f, 6'h08);
    i_mst.byte_io(8'h54, b);
    chk_flags(6'h3f, 6'h39);
    ack(1'b0);
    chk_flags(6'h20, 6'h00);
    i_mst.byte_io(8'ha5, b);
    ack(1'b0);
    axi(1'b0, ssf_pkg::OFS_DATA, 32'h0, 2'h0);
    chk(rv, 32'ha5);
    axi(1'b1, ssf_pkg::OFS_CTRL, 32'h08, 2'h0);
    i_mst.byte_io(8'h3c, b);
    ack(1'b1);
    i_mst.stop();
    chk_flags(6'h08, 6'h00);
  endtask
  task automatic t_read();
    axi(1'b1, ssf_pkg::OFS_CTRL, 32'h10, 2'h0);
    axi(1'b1, ssf_pkg::OFS_DATA, 32'hc3, 2'h0);
    i_mst.start();
    i_mst.byte_io(8'h55, b);
    chk_flags(6'h36, 6'h36);
    ack(1'b0);
    i_mst.byte_io(8'hff, b);
    chk({24'h0, b}, 32'hc3);
    chk_flags(6'h20, 6'h20);
    ack(1'b1);
    i_mst.stop();
  endtask
  task automatic t_miss();
    axi(1'b1, ssf_pkg::OFS_IMASK, 32'h0, 2'h0);
    axi(1'b1, ssf_pkg::OFS_ISTAT, 32'hf, 2'h0);
    i_mst.start();
    i_mst.byte_io(8'h2a, b);
    chk_flags(6'h11, 6'h00);
    ack(1'b1);
    i_mst.stop();
    axi(1'b0, ssf_pkg::OFS_ISTAT, 32'h0, 2'h0);
    chk(rv & 32'he, 32'hc);
    axi(1'b1, ssf_pkg::OFS_IMASK, 32'h4, 2'h0);
    chk_flags(6'h01, 6'h01);
    axi(1'b1, ssf_pkg::OFS_ISTAT, 32'h4, 2'h0);
    chk_flags(6'h01, 6'h00);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_write();
    t_read();
    t_miss();
    final_report();
  end
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
endmodule // testbench
bind ssf_top ssf_chk #(.ADDR_W(ADDR_W)) i_chk (.mclk, .srst,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .scl_i, .sda_i, .sda_oe, .byte_done_flag,
  .addr_match_flag, .bus_busy_flag, .master_dir_flag, .slave_tx_select,
  .irq);
